/* File: fan_alert_pwm_regs_consts.svh */
// constants for the fan alert and pwm register bank
`ifndef FAN_ALERT_PWM_REGS_CONSTS_SVH
`define FAN_ALERT_PWM_REGS_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_INT_STATUS 8'h23
`define IDX_HIGH_STATUS 8'h24
`define IDX_LOW_STATUS 8'h25
`define IDX_FAN_FAULT_FLAGS 8'h27
`define IDX_TEMP_CHANNEL_ALERT_MASK 8'h28
`define IDX_FAN_ALERT_MASK 8'h29
`define IDX_PWM_OUTPUT_CONFIG 8'h2a
`define IDX_PWM_BASE_RATE 8'h2b
`define IDX_REMOTE1_HIGH_LIMIT 8'h30
`define IDX_REMOTE2_HIGH_LIMIT 8'h31
`define IDX_REMOTE3_HIGH_LIMIT 8'h32
`define IDX_ONCHIP_HIGH_LIMIT 8'h34
`define IDX_REMOTE1_LOW_LIMIT 8'h38
`define IDX_REMOTE2_LOW_LIMIT 8'h39
`define IDX_REMOTE3_LOW_LIMIT 8'h3a
`define IDX_ONCHIP_LOW_LIMIT 8'h3c
`define IDX_FAN_DRIVE_SETTING 8'h40

// field positions
`define BIT_HOST_TIMEOUT 7
`define BIT_TARGET_UNREACHABLE 5
`define BIT_SPINUP_FAILED 1
`define BIT_STALLED_ROTOR 0
`define BIT_SPIN_ALERT_ALLOW 1
`define BIT_STALL_ALERT_ALLOW 0
`define BIT_OUTPUT_DRIVE_TYPE 4
`define BIT_OUTPUT_INVERT 0
`define BIT_INT_FAN 3
`define BIT_INT_HIGH 2
`define BIT_INT_LOW 1

// reset values
`define RST_ZERO 8'h00
`define RST_BASE_RATE 8'h03
`define RST_HIGH_LIMIT 8'h55
`define RST_LOW_LIMIT 8'h00

// timing
`define CLK_HZ 100000000
`define HOST_TIMEOUT_S 4
`define PWM_STEPS 255
`define PWM_FULL_DUTY 8'hff
`define BASE_HZ_0 26000
`define BASE_HZ_1 19531
`define BASE_HZ_2 4882
`define BASE_HZ_3 2441

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: fan_alert_pwm_regs_pkg.sv */
// types shared by the fan alert and pwm register bank
package fan_alert_pwm_regs_pkg;
   typedef logic [7:0] reg8_t;
   typedef enum logic [1:0] {rate_26k, rate_19k5, rate_4k9, rate_2k4} base_rate_e;
endpackage

/* File: fan_alert_pwm_regs.sv */
// fan fault flags, alert masking, temperature limits and pwm fan driver behind an axi4-lite slave
//
// Operation
// - set host timeout flag if fan drive unwritten four seconds after reset.
// - set target unreachable flag while algorithm cannot reach target at full drive.
// - set spin-up failed flag when spin-up gets no valid tach reading.
// - set stalled rotor flag when tach measurement sees a stalled fan.
// - four channel mask bits, reset zero; masked channels never assert attention; the code lets a channel assert it only while its mask bit is set.
// - spin alert allow gates only attention; spin flag still recorded.
// - stall alert allow gates stall and unreachable flags onto attention together.
// - drive type bit: zero open drain, one push-pull.
// - inversion bit flips duty: 00h gives 100 percent, ffh zero.
// - base rate select picks 26k, 19.531k, 4882 or 2441 hz; reset 2441.
// - set channel high bit when measurement at or above high limit.
// - set channel low bit when measurement strictly below low limit.
// - limit register writes ignored while software lock engaged.
// - drive setting reads return the drive currently applied to the fan.
// - drive setting is read-only while algorithm or lookup table active.
// - with both disabled drive keeps last value and writes change it.
// - duty equals drive setting over 255 before inversion.
// - reading a status register clears only bits whose condition has gone.
// - attention low while any enabled status bit set, released otherwise.
// - cooling summary bit set while any fan fault flag is set.
`timescale 1ns/100ps
`default_nettype none
`include "fan_alert_pwm_regs_consts.svh"

module fan_alert_pwm_regs
#(
   parameter int unsigned HOST_TIMEOUT_CYCLES = `CLK_HZ * `HOST_TIMEOUT_S,
   parameter int unsigned CHANNELS = 4
)
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   // axi4-lite slave
   input wire logic [9:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [9:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // conditions from tach, spin-up and speed logic
   input wire logic target_unreachable_in,
   input wire logic spinup_failed_in,
   input wire logic stalled_rotor_in,
   input wire logic speed_control_algorithm_active_in,
   input wire logic lookup_table_active_in,
   input wire logic [7:0] auto_drive_in,
   input wire logic software_lock_in,
   // measurements, index 0 on-chip, 1..3 remote sensors 1..3
   input wire logic [CHANNELS-1:0][7:0] temperature_in,
   // pins
   output logic alert_n_out,
   output logic pwm_out,
   output logic pwm_oe_n_out
);

   localparam int unsigned SLOT0 = `CLK_HZ / (`BASE_HZ_0 * `PWM_STEPS);
   localparam int unsigned SLOT1 = `CLK_HZ / (`BASE_HZ_1 * `PWM_STEPS);
   localparam int unsigned SLOT2 = `CLK_HZ / (`BASE_HZ_2 * `PWM_STEPS);
   localparam int unsigned SLOT3 = `CLK_HZ / (`BASE_HZ_3 * `PWM_STEPS);

   fan_alert_pwm_regs_pkg::reg8_t fan_flags_q, fan_flags_d;
   fan_alert_pwm_regs_pkg::reg8_t chan_mask_q, fan_mask_q, pwm_cfg_q, base_rate_q, drive_q;
   logic [CHANNELS-1:0] high_stat_q, high_stat_d, low_stat_q, low_stat_d;
   logic [CHANNELS-1:0] high_cond, low_cond;
   logic [7:0] high_lim_q [CHANNELS];
   logic [7:0] low_lim_q [CHANNELS];

   // bus state
   logic aw_held_q, w_held_q;
   logic [7:0] aw_idx_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] ar_idx;
   logic [7:0] rd_val;
   logic rd_hit;
   logic wr_hit;
   logic wr_lane0;

   // watchdog
   logic [31:0] wdog_cnt_q;
   logic wdog_armed_q;
   logic wdog_fire;

   // pwm
   logic [15:0] slot_cnt_q;
   logic [7:0] step_q;
   logic [15:0] slot_len;
   logic pwm_level;
   logic pwm_q, pwm_oe_n_q;
   logic alert_n_q;
   logic auto_mode;
   fan_alert_pwm_regs_pkg::reg8_t fan_cond;

   // ---------------- axi4-lite write path ----------------
   assign s_axi_awready_out = !aw_held_q && !s_axi_bvalid_out;
   assign s_axi_wready_out = !w_held_q && !s_axi_bvalid_out;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid_out;
   assign wr_lane0 = wstrb_q[0];

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         aw_held_q <= 1'b0;
         aw_idx_q <= 8'h00;
      end
      else if (s_axi_awvalid_in && s_axi_awready_out)
      begin
         aw_held_q <= 1'b1;
         aw_idx_q <= s_axi_awaddr_in[9:2];
      end
      else if (wr_fire)
      begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (s_axi_wvalid_in && s_axi_wready_out)
      begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata_in;
         wstrb_q <= s_axi_wstrb_in;
      end
      else if (wr_fire)
      begin
         w_held_q <= 1'b0;
      end
   end

   always_comb
   begin
      case (aw_idx_q)
         `IDX_INT_STATUS, `IDX_HIGH_STATUS, `IDX_LOW_STATUS, `IDX_FAN_FAULT_FLAGS,
         `IDX_TEMP_CHANNEL_ALERT_MASK, `IDX_FAN_ALERT_MASK, `IDX_PWM_OUTPUT_CONFIG,
         `IDX_PWM_BASE_RATE, `IDX_REMOTE1_HIGH_LIMIT, `IDX_REMOTE2_HIGH_LIMIT,
         `IDX_REMOTE3_HIGH_LIMIT, `IDX_ONCHIP_HIGH_LIMIT, `IDX_REMOTE1_LOW_LIMIT,
         `IDX_REMOTE2_LOW_LIMIT, `IDX_REMOTE3_LOW_LIMIT, `IDX_ONCHIP_LOW_LIMIT,
         `IDX_FAN_DRIVE_SETTING: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready_in)
      begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // ---------------- plain control registers ----------------
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         chan_mask_q <= `RST_ZERO;
         fan_mask_q <= `RST_ZERO;
         pwm_cfg_q <= `RST_ZERO;
         base_rate_q <= `RST_BASE_RATE;
      end
      else if (wr_fire && wr_lane0)
      begin
         case (aw_idx_q)
            `IDX_TEMP_CHANNEL_ALERT_MASK: chan_mask_q <= {4'h0, wdata_q[3:0]};
            `IDX_FAN_ALERT_MASK: fan_mask_q <= {6'h00, wdata_q[1:0]};
            `IDX_PWM_OUTPUT_CONFIG: pwm_cfg_q <= {3'h0, wdata_q[4], 3'h0, wdata_q[0]};
            `IDX_PWM_BASE_RATE: base_rate_q <= {6'h00, wdata_q[1:0]};
            default: chan_mask_q <= chan_mask_q;
         endcase
      end
   end

   // limits, index 0 on-chip, 1..3 remote
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            high_lim_q[i] <= `RST_HIGH_LIMIT;
            low_lim_q[i] <= `RST_LOW_LIMIT;
         end
      end
      else if (wr_fire && wr_lane0 && !software_lock_in)
      begin
         case (aw_idx_q)
            `IDX_ONCHIP_HIGH_LIMIT: high_lim_q[0] <= wdata_q[7:0];
            `IDX_REMOTE1_HIGH_LIMIT: high_lim_q[1] <= wdata_q[7:0];
            `IDX_REMOTE2_HIGH_LIMIT: high_lim_q[2] <= wdata_q[7:0];
            `IDX_REMOTE3_HIGH_LIMIT: high_lim_q[3] <= wdata_q[7:0];
            `IDX_ONCHIP_LOW_LIMIT: low_lim_q[0] <= wdata_q[7:0];
            `IDX_REMOTE1_LOW_LIMIT: low_lim_q[1] <= wdata_q[7:0];
            `IDX_REMOTE2_LOW_LIMIT: low_lim_q[2] <= wdata_q[7:0];
            `IDX_REMOTE3_LOW_LIMIT: low_lim_q[3] <= wdata_q[7:0];
            default: high_lim_q[0] <= high_lim_q[0];
         endcase
      end
   end

   // ---------------- fan drive setting ----------------
   assign auto_mode = speed_control_algorithm_active_in || lookup_table_active_in;

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         drive_q <= `RST_ZERO;
      end
      else if (auto_mode)
      begin
         drive_q <= auto_drive_in;
      end
      else if (wr_fire && wr_lane0 && aw_idx_q == `IDX_FAN_DRIVE_SETTING)
      begin
         drive_q <= wdata_q[7:0];
      end
   end

   // ---------------- host timeout watchdog ----------------
   assign wdog_fire = wdog_armed_q && (wdog_cnt_q == HOST_TIMEOUT_CYCLES - 1);

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wdog_cnt_q <= 32'h0000_0000;
         wdog_armed_q <= 1'b1;
      end
      else if (wdog_armed_q)
      begin
         // any write to the drive setting counts as programming the driver
         if (wr_fire && aw_idx_q == `IDX_FAN_DRIVE_SETTING)
            wdog_armed_q <= 1'b0;
         else if (wdog_fire)
            wdog_armed_q <= 1'b0;
         else
            wdog_cnt_q <= wdog_cnt_q + 32'h0000_0001;
      end
   end

   // ---------------- read path ----------------
   assign ar_idx = s_axi_araddr_in[9:2];
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;

   always_comb
   begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      case (ar_idx)
         `IDX_INT_STATUS:
         begin
            rd_val[`BIT_INT_FAN] = |fan_flags_q;
            rd_val[`BIT_INT_HIGH] = |high_stat_q;
            rd_val[`BIT_INT_LOW] = |low_stat_q;
         end
         `IDX_HIGH_STATUS: rd_val = {4'h0, high_stat_q};
         `IDX_LOW_STATUS: rd_val = {4'h0, low_stat_q};
         `IDX_FAN_FAULT_FLAGS: rd_val = fan_flags_q;
         `IDX_TEMP_CHANNEL_ALERT_MASK: rd_val = chan_mask_q;
         `IDX_FAN_ALERT_MASK: rd_val = fan_mask_q;
         `IDX_PWM_OUTPUT_CONFIG: rd_val = pwm_cfg_q;
         `IDX_PWM_BASE_RATE: rd_val = base_rate_q;
         `IDX_ONCHIP_HIGH_LIMIT: rd_val = high_lim_q[0];
         `IDX_REMOTE1_HIGH_LIMIT: rd_val = high_lim_q[1];
         `IDX_REMOTE2_HIGH_LIMIT: rd_val = high_lim_q[2];
         `IDX_REMOTE3_HIGH_LIMIT: rd_val = high_lim_q[3];
         `IDX_ONCHIP_LOW_LIMIT: rd_val = low_lim_q[0];
         `IDX_REMOTE1_LOW_LIMIT: rd_val = low_lim_q[1];
         `IDX_REMOTE2_LOW_LIMIT: rd_val = low_lim_q[2];
         `IDX_REMOTE3_LOW_LIMIT: rd_val = low_lim_q[3];
         `IDX_FAN_DRIVE_SETTING: rd_val = drive_q;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= {24'h00_0000, rd_val};
         s_axi_rresp_out <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready_in)
      begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // ---------------- status flags: set wins, read clears only gone conditions ----------------
   always_comb
   begin
      fan_cond = 8'h00;
      fan_cond[`BIT_HOST_TIMEOUT] = wdog_fire;
      fan_cond[`BIT_TARGET_UNREACHABLE] = target_unreachable_in;
      fan_cond[`BIT_SPINUP_FAILED] = spinup_failed_in;
      fan_cond[`BIT_STALLED_ROTOR] = stalled_rotor_in;
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_chan
         assign high_cond[ch] = $signed(temperature_in[ch]) >= $signed(high_lim_q[ch]);
         assign low_cond[ch] = $signed(temperature_in[ch]) < $signed(low_lim_q[ch]);
      end
   endgenerate

   always_comb
   begin
      fan_flags_d = fan_flags_q;
      high_stat_d = high_stat_q;
      low_stat_d = low_stat_q;
      if (rd_fire && ar_idx == `IDX_FAN_FAULT_FLAGS)
         fan_flags_d = fan_flags_q & fan_cond;
      if (rd_fire && ar_idx == `IDX_HIGH_STATUS)
         high_stat_d = high_stat_q & high_cond;
      if (rd_fire && ar_idx == `IDX_LOW_STATUS)
         low_stat_d = low_stat_q & low_cond;
      fan_flags_d = fan_flags_d | fan_cond;
      high_stat_d = high_stat_d | high_cond;
      low_stat_d = low_stat_d | low_cond;
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         fan_flags_q <= `RST_ZERO;
         high_stat_q <= '0;
         low_stat_q <= '0;
      end
      else
      begin
         fan_flags_q <= fan_flags_d;
         high_stat_q <= high_stat_d;
         low_stat_q <= low_stat_d;
      end
   end

   // ---------------- attention output ----------------
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         alert_n_q <= 1'b1;
      end
      else
      begin
         alert_n_q <= !(
            fan_flags_q[`BIT_HOST_TIMEOUT] ||
            (fan_flags_q[`BIT_SPINUP_FAILED] && fan_mask_q[`BIT_SPIN_ALERT_ALLOW]) ||
            ((fan_flags_q[`BIT_STALLED_ROTOR] || fan_flags_q[`BIT_TARGET_UNREACHABLE]) &&
             fan_mask_q[`BIT_STALL_ALERT_ALLOW]) ||
            (|((high_stat_q | low_stat_q) & chan_mask_q[CHANNELS-1:0])));
      end
   end
   assign alert_n_out = alert_n_q;

   // ---------------- pwm driver ----------------
   always_comb
   begin
      case (fan_alert_pwm_regs_pkg::base_rate_e'(base_rate_q[1:0]))
         fan_alert_pwm_regs_pkg::rate_26k: slot_len = 16'(SLOT0);
         fan_alert_pwm_regs_pkg::rate_19k5: slot_len = 16'(SLOT1);
         fan_alert_pwm_regs_pkg::rate_4k9: slot_len = 16'(SLOT2);
         fan_alert_pwm_regs_pkg::rate_2k4: slot_len = 16'(SLOT3);
         default: slot_len = 16'(SLOT3);
      endcase
   end

   // 255 steps of slot_len cycles form one period
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         slot_cnt_q <= 16'h0000;
         step_q <= 8'h00;
      end
      else if (slot_cnt_q >= slot_len - 16'h0001)
      begin
         slot_cnt_q <= 16'h0000;
         step_q <= (step_q >= 8'(`PWM_STEPS - 1)) ? 8'h00 : step_q + 8'h01;
      end
      else
      begin
         slot_cnt_q <= slot_cnt_q + 16'h0001;
      end
   end

   // high for drive_q of 255 steps before inversion, so uninverted ffh holds the output high all period
   assign pwm_level = (step_q < drive_q) ^ pwm_cfg_q[`BIT_OUTPUT_INVERT];

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         pwm_q <= 1'b0;
         pwm_oe_n_q <= 1'b1;
      end
      else if (pwm_cfg_q[`BIT_OUTPUT_DRIVE_TYPE])
      begin
         pwm_q <= pwm_level;
         pwm_oe_n_q <= 1'b0;
      end
      else
      begin
         pwm_q <= 1'b0;
         pwm_oe_n_q <= pwm_level;
      end
   end
   assign pwm_out = pwm_q;
   assign pwm_oe_n_out = pwm_oe_n_q;

endmodule
`default_nettype wire

/* File: fan_alert_pwm_regs_sva.sv */
// assertion checker bound to the fan alert and pwm register bank ports
`timescale 1ns/100ps
`default_nettype none
`include "fan_alert_pwm_regs_consts.svh"
module fan_alert_pwm_regs_sva
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic [9:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rvalid_out,
   input wire logic spinup_failed_in,
   input wire logic stalled_rotor_in,
   input wire logic speed_control_algorithm_active_in,
   input wire logic [7:0] auto_drive_in,
   input wire logic pwm_out,
   input wire logic pwm_oe_n_out
);
   logic rd_go;
   logic rd_flags;
   assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
   assign rd_flags = rd_go && s_axi_araddr_in[9:2] == `IDX_FAN_FAULT_FLAGS;
   default clocking dclk @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   property p_read_answer;
      rd_go |=> s_axi_rvalid_out;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_read_refuse;
      s_axi_rvalid_out |-> !s_axi_arready_out;
   endproperty
   a_read_refuse: assert property (p_read_refuse) else $error("read taken while answer pending");
   property p_write_answer;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |=> !s_axi_bvalid_out ##1
         s_axi_bvalid_out;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write answer timing");
   property p_unmapped;
      rd_go && s_axi_araddr_in[9:2] == 8'h00 |=> s_axi_rresp_out == `RESP_SLVERR && s_axi_rdata_out == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");
   property p_stall_flag;
      rd_flags && $past(reset_n_in) && $past(stalled_rotor_in) |=> s_axi_rdata_out[`BIT_STALLED_ROTOR];
   endproperty
   a_stall_flag: assert property (p_stall_flag) else $error("stall flag missing");
   property p_spin_flag;
      rd_flags && $past(reset_n_in) && $past(spinup_failed_in) |=> s_axi_rdata_out[`BIT_SPINUP_FAILED];
   endproperty
   a_spin_flag: assert property (p_spin_flag) else $error("spin flag missing");
   property p_auto_drive;
      rd_go && s_axi_araddr_in[9:2] == `IDX_FAN_DRIVE_SETTING && $past(reset_n_in) &&
         $past(speed_control_algorithm_active_in) && $stable(auto_drive_in) |=> s_axi_rdata_out[7:0] == $past(auto_drive_in);
   endproperty
   a_auto_drive: assert property (p_auto_drive) else $error("drive read not applied value");
   property p_pin_drive;
      pwm_out |-> !pwm_oe_n_out;
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pin driven high while released");
endmodule
bind fan_alert_pwm_regs fan_alert_pwm_regs_sva i_sva
(
   .clk_in(clk_in), .reset_n_in(reset_n_in), .s_axi_awvalid_in(s_axi_awvalid_in),
   .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .spinup_failed_in(spinup_failed_in), .stalled_rotor_in(stalled_rotor_in),
   .speed_control_algorithm_active_in(speed_control_algorithm_active_in), .auto_drive_in(auto_drive_in),
   .pwm_out(pwm_out), .pwm_oe_n_out(pwm_oe_n_out)
);
`default_nettype wire

/* File: cooling_fan_model.sv */
// cooling fan model: resolves the pwm pin and measures its period and high time
`timescale 1ns/100ps
`default_nettype none
module cooling_fan_model
(
   input wire logic clk_in,
   input wire logic pwm_in,
   input wire logic pwm_oe_n_in,
   output var int period_out,
   output var int high_out,
   output var int edges_out
);
   logic pin;
   logic pin_q = 1'b1;
   int cnt = 0;
   int hcnt = 0;
   // fan input pulls a released pin high
   assign pin = pwm_oe_n_in ? 1'b1 : pwm_in;
   always @(posedge clk_in)
   begin
      pin_q <= pin;
      cnt <= cnt + 1;
      hcnt <= hcnt + int'(pin);
      if (pin && !pin_q)
      begin
         period_out <= cnt;
         high_out <= hcnt;
         cnt <= 1;
         hcnt <= 1;
         edges_out <= edges_out + 1;
      end
   end
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking testbench for the fan alert and pwm register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [9:0] aw_addr = 10'h000;
   logic [9:0] ar_addr = 10'h000;
   logic [31:0] w_data = 32'h00000000;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
   logic stall = 1'b0, spin = 1'b0, unreach = 1'b0, algo = 1'b0, lookup_table = 1'b0, lock = 1'b0;
   logic [7:0] auto_drive = 8'h00;
   logic [7:0] v;
   logic [3:0][7:0] temp = {4{8'h20}};
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid, alert_n, pwm, pwm_oe_n;
   logic [1:0] b_resp, r_resp;
   logic [31:0] r_data;
   logic [33:0] exp_q[$];
   logic [15:0] rst_tab [14] = '{16'h2700, 16'h2800, 16'h2900, 16'h2a00, 16'h2b03, 16'h3055, 16'h3155, 16'h3255,
      16'h3455, 16'h3800, 16'h3900, 16'h3a00, 16'h3c00, 16'h4000};
   int period, high, edges;
   int failures = 0;
   int n_checks = 0;
   integer seed = 32'haad5059b;
   fan_alert_pwm_regs #(.HOST_TIMEOUT_CYCLES(200)) i_dut
   (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid),
      .s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(w_valid),
      .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
      .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid), .s_axi_arready_out(ar_ready),
      .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready),
      .target_unreachable_in(unreach), .spinup_failed_in(spin), .stalled_rotor_in(stall),
      .speed_control_algorithm_active_in(algo), .lookup_table_active_in(lookup_table), .auto_drive_in(auto_drive),
      .software_lock_in(lock), .temperature_in(temp), .alert_n_out(alert_n), .pwm_out(pwm), .pwm_oe_n_out(pwm_oe_n)
   );
   cooling_fan_model i_fan
   (
      .clk_in(clk_in), .pwm_in(pwm), .pwm_oe_n_in(pwm_oe_n), .period_out(period), .high_out(high), .edges_out(edges)
   );
   initial
   begin
      forever #5 clk_in = ~clk_in;
   end
   task chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_in);
      aw_addr <= {idx, 2'b00};
      w_data <= {24'h000000, d};
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      exp_q.push_back(34'h000000000);
      do
      begin
         @(posedge clk_in);
         if (aw_ready)
            aw_valid <= 1'b0;
         if (w_ready)
            w_valid <= 1'b0;
      end
      while (aw_valid || w_valid);
      do @(posedge clk_in); while (!b_valid);
      b_ready <= 1'b0;
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp = 2'h0);
      @(posedge clk_in);
      ar_addr <= {idx, 2'b00};
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      exp_q.push_back({resp, 24'h000000, d});
      do @(posedge clk_in); while (!ar_ready);
      ar_valid <= 1'b0;
      do @(posedge clk_in); while (!r_valid);
      r_ready <= 1'b0;
   endtask
   task alert(input logic e);
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk("alert_n", {33'h0, alert_n}, {33'h0, e});
      @(posedge clk_in);
   endtask
   task meas(input int hi, input int per);
      int e0;
      e0 = edges;
      while (edges < e0 + 3) @(posedge clk_in);
      chk("high_time", 34'(high), 34'(hi));
      chk("period", 34'(period), 34'(per));
   endtask
   task end_sim;
      if (failures == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // compares each bus answer with the oldest note
   always @(posedge clk_in)
   begin
      if (b_valid && b_ready)
         chk("write_resp", {b_resp, 32'h00000000}, exp_q.pop_front());
      else if (r_valid && r_ready)
         chk("read_data", {r_resp, r_data}, exp_q.pop_front());
   end
   initial
   begin
      #700000;
      failures++;
      end_sim;
   end
   initial
   begin
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      for (int i = 0; i < 14; i++)
         rd(rst_tab[i][15:8], rst_tab[i][7:0]);
      rd(8'h00, 8'h00, 2'h2);
      alert(1'b1);
      repeat (200) @(posedge clk_in);
      alert(1'b0);
      rd(8'h27, 8'h80);
      rd(8'h27, 8'h00);
      alert(1'b1);
      stall <= 1'b1;
      spin <= 1'b1;
      unreach <= 1'b1;
      alert(1'b1);
      rd(8'h23, 8'h08);
      rd(8'h27, 8'h23);
      rd(8'h27, 8'h23);
      wr(8'h29, 8'h02);
      alert(1'b0);
      spin <= 1'b0;
      rd(8'h27, 8'h23);
      rd(8'h27, 8'h21);
      alert(1'b1);
      wr(8'h29, 8'h01);
      alert(1'b0);
      stall <= 1'b0;
      rd(8'h27, 8'h21);
      rd(8'h27, 8'h20);
      alert(1'b0);
      unreach <= 1'b0;
      rd(8'h27, 8'h20);
      rd(8'h27, 8'h00);
      rd(8'h23, 8'h00);
      alert(1'b1);
      v = 8'($random(seed));
      temp <= {8'h20, {2'b00, v[5:0]}, 8'h55, 8'hff};
      alert(1'b1);
      rd(8'h24, 8'h02);
      rd(8'h25, 8'h01);
      rd(8'h23, 8'h06);
      wr(8'h28, 8'h0c);
      alert(1'b1);
      wr(8'h28, 8'h02);
      alert(1'b0);
      temp[1] <= 8'h54;
      rd(8'h24, 8'h02);
      rd(8'h24, 8'h00);
      lock <= 1'b1;
      wr(8'h30, 8'h10);
      rd(8'h30, 8'h55);
      lock <= 1'b0;
      v = 8'($random(seed));
      wr(8'h30, v);
      rd(8'h30, v);
      v = 8'($random(seed));
      algo <= 1'b1;
      auto_drive <= v;
      wr(8'h40, 8'h33);
      rd(8'h40, v);
      algo <= 1'b0;
      lookup_table <= 1'b1;
      auto_drive <= ~v;
      wr(8'h40, 8'h44);
      rd(8'h40, ~v);
      lookup_table <= 1'b0;
      rd(8'h40, ~v);
      wr(8'h40, 8'h80);
      rd(8'h40, 8'h80);
      wr(8'h2b, 8'h00);
      wr(8'h2a, 8'h10);
      meas(1920, 3825);
      chk("pwm_oe_n", {33'h0, pwm_oe_n}, 34'h0);
      wr(8'h2a, 8'h00);
      meas(1920, 3825);
      chk("pwm_out", {33'h0, pwm}, 34'h0);
      wr(8'h2a, 8'h11);
      meas(1905, 3825);
      wr(8'h2b, 8'h02);
      rd(8'h2b, 8'h02);
      wr(8'h2b, 8'h01);
      wr(8'h2a, 8'h10);
      wr(8'h40, 8'h01);
      meas(20, 5100);
      end_sim;
   end
endmodule
`default_nettype wire
